// [hdl/slm_regs.vh]
// Register map, field positions, reset values and timing counts of the supply level monitor
`ifndef SLM_REGS_VH
`define SLM_REGS_VH

// ----------------------------------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------------------------------
`define SLM_IDX_CONTROL 30'h00000F2F
`define SLM_IDX_LEVEL 30'h00000F30
`define SLM_IDX_STATUS 30'h00000F31

// ----------------------------------------------------------------
// voltage_detect_control fields
// ----------------------------------------------------------------
`define SLM_CTL_ENABLE_BIT 7
`define SLM_CTL_OUT_BIT 5
`define SLM_CTL_READY_BIT 4
`define SLM_CTL_RISE_BIT 1
`define SLM_CTL_DROP_BIT 0

// ----------------------------------------------------------------
// voltage_detect_level and status fields
// ----------------------------------------------------------------
`define SLM_LVL_MSB 3
`define SLM_LVL_RESERVED 4'hF
`define SLM_STS_FLAG_BIT 0
`define SLM_STS_IE_BIT 1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SLM_RST_ENABLE 1'b0
`define SLM_RST_RISE 1'b0
`define SLM_RST_DROP 1'b0
`define SLM_RST_LEVEL 4'h0
`define SLM_RST_FLAG 1'b0
`define SLM_RST_IE 1'b0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SLM_CLK_PERIOD_NS 10
`define SLM_SETTLE_NS 25000
`define SLM_SETTLE_CYCLES ((`SLM_SETTLE_NS + `SLM_CLK_PERIOD_NS - 1) / `SLM_CLK_PERIOD_NS)
`define SLM_SETTLE_WIDTH 12

`endif

// [hdl/slm_sync2.v]
// Two-flop synchroniser for the asynchronous comparator level
`timescale 1ns/1ps

module slm_sync2 (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // Level
  input wire async_in,
  output wire sync_out
);

  reg meta_reg;
  reg sync_reg;

  // ----------------------------------------------------------------
  // Synchroniser
  // ----------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;

endmodule // slm_sync2

// [hdl/slm_settle_timer.v]
// Reference settling timer that raises ready a fixed time after enable
`timescale 1ns/1ps
`include "slm_regs.vh"

module slm_settle_timer (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // Control
  input wire run,
  output wire ready
);

  localparam integer LAST_INT = `SLM_SETTLE_CYCLES - 1;
  // Cut on purpose: the count fits the counter width
  localparam [`SLM_SETTLE_WIDTH-1:0] LAST_CNT = LAST_INT[`SLM_SETTLE_WIDTH-1:0];

  reg [`SLM_SETTLE_WIDTH-1:0] count_reg;
  reg done_reg;

  // ----------------------------------------------------------------
  // Count restarts from zero on each enable
  // ----------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_reg <= {`SLM_SETTLE_WIDTH{1'b0}};
      done_reg <= 1'b0;
    end else if (!run) begin
      count_reg <= {`SLM_SETTLE_WIDTH{1'b0}};
      done_reg <= 1'b0;
    end else if (count_reg == LAST_CNT) begin
      done_reg <= 1'b1;
    end else begin
      count_reg <= count_reg + {{(`SLM_SETTLE_WIDTH-1){1'b0}}, 1'b1};
    end
  end

  // Drops in the same cycle as the enable so no late event slips through
  assign ready = done_reg & run;

endmodule // slm_settle_timer

// [hdl/slm_supply_level_monitor.v]
// Supply level monitor control, status and event logic with AHB-Lite register slave
//
// Overview of operation
// - Setting or clearing the enable bit never raises a false event.
// - Ready bit 4 reads 0 after each enable until settled, then 1.
// - Settling interval is a fixed time, converted to cycles from the clock rate.
// - Rise enable bit 1 sets the event flag when supply is above limit.
// - Drop enable bit 0 sets the event flag when supply is at or below limit.
// - Both direction enables set flag crossings in either direction.
// - Comparator bit 5 reads 1 at or below the limit, 0 above; it reads 0 while enable bit 7 is 0.
// - Four-bit trip level select; codes 0 to 14 ascend, code 15 reserved.
// - No detection events while ready is 0.
// - Flag cleared while the condition holds is set again.
// - Monitoring continues in sleep; event wakes device, vectors only if globally enabled.
// - Idle and doze keep the module fully active.
// - Any reset turns the module off; enable and direction bits reset to 0.
// - Trip level resets to 0 only on power-on or brown-out reset.
// - Enable bit 7 powers the comparator and divider up or down.
`timescale 1ns/1ps
`include "slm_regs.vh"

module slm_supply_level_monitor (
  // Clock and resets
  input wire hclk,
  input wire hresetn,
  input wire por_bor_resetn,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output wire [31:0] hrdata,
  // Analog front end
  input wire supply_below_trip,
  output wire analog_power_en,
  output wire [3:0] trip_level_sel,
  // Power mode and interrupt controller
  input wire sleep_mode,
  input wire global_irq_enable,
  output wire irq_req,
  output wire wake_req,
  output wire irq_vector_req
);

  // ----------------------------------------------------------------
  // Bus states and register selects
  // ----------------------------------------------------------------
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_WRITE = 4'h2;
  localparam [3:0] ST_RDWAIT = 4'h4;
  localparam [3:0] ST_RDDONE = 4'h8;

  localparam [1:0] SEL_NONE = 2'h0;
  localparam [1:0] SEL_CTRL = 2'h1;
  localparam [1:0] SEL_LEVEL = 2'h2;
  localparam [1:0] SEL_STATUS = 2'h3;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function [1:0] slm_decode;
    input [31:0] addr;
    begin
      if (addr[31:2] == `SLM_IDX_CONTROL) begin
        slm_decode = SEL_CTRL;
      end else if (addr[31:2] == `SLM_IDX_LEVEL) begin
        slm_decode = SEL_LEVEL;
      end else if (addr[31:2] == `SLM_IDX_STATUS) begin
        slm_decode = SEL_STATUS;
      end else begin
        slm_decode = SEL_NONE;
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  reg [3:0] state_reg;
  reg [3:0] state_next;
  reg [1:0] dp_sel_reg;
  reg [31:0] hrdata_reg;
  reg [7:0] read_byte;

  reg enable_reg;
  reg rise_en_reg;
  reg drop_en_reg;
  reg [3:0] level_reg;
  reg flag_reg;
  reg flag_next;
  reg ie_reg;

  wire accept;
  wire wr_strobe;
  wire wr_ctrl;
  wire wr_level;
  wire wr_status;
  wire below_sync;
  wire ready;
  wire out_bit;
  wire rise_hit;
  wire drop_hit;
  wire level_valid;
  wire detect_event;

  // ----------------------------------------------------------------
  // AHB-Lite data phase tracking
  // ----------------------------------------------------------------
  assign accept = hsel & htrans[1] & hready;

  always @* begin
    state_next = ST_IDLE;
    case (state_reg)
      ST_IDLE, ST_WRITE, ST_RDDONE: begin
        if (accept) begin
          state_next = hwrite ? ST_WRITE : ST_RDWAIT;
        end else begin
          state_next = ST_IDLE;
        end
      end
      ST_RDWAIT: begin
        state_next = ST_RDDONE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= ST_IDLE;
      dp_sel_reg <= SEL_NONE;
    end else begin
      state_reg <= state_next;
      if (accept) begin
        dp_sel_reg <= slm_decode(haddr);
      end
    end
  end

  // One wait state on reads so read data come from a flop and see the latest write
  assign hreadyout = (state_reg != ST_RDWAIT);
  assign hresp = 1'b0;

  assign wr_strobe = (state_reg == ST_WRITE);
  assign wr_ctrl = wr_strobe & (dp_sel_reg == SEL_CTRL);
  assign wr_level = wr_strobe & (dp_sel_reg == SEL_LEVEL);
  assign wr_status = wr_strobe & (dp_sel_reg == SEL_STATUS);

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      enable_reg <= `SLM_RST_ENABLE;
      rise_en_reg <= `SLM_RST_RISE;
      drop_en_reg <= `SLM_RST_DROP;
    end else if (wr_ctrl) begin
      enable_reg <= hwdata[`SLM_CTL_ENABLE_BIT];
      rise_en_reg <= hwdata[`SLM_CTL_RISE_BIT];
      drop_en_reg <= hwdata[`SLM_CTL_DROP_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Level register, cleared only by power-on or brown-out reset
  // ----------------------------------------------------------------
  always @(posedge hclk or negedge por_bor_resetn) begin
    if (!por_bor_resetn) begin
      level_reg <= `SLM_RST_LEVEL;
    end else if (wr_level) begin
      level_reg <= hwdata[`SLM_LVL_MSB:0];
    end
  end

  assign trip_level_sel = level_reg;
  assign analog_power_en = enable_reg;

  // ----------------------------------------------------------------
  // Comparator path and settling
  // ----------------------------------------------------------------
  slm_sync2 u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in(supply_below_trip),
    .sync_out(below_sync)
  );

  slm_settle_timer u_settle (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(enable_reg),
    .ready(ready)
  );

  // Reads 0 while powered down since the comparator output is meaningless then
  assign out_bit = enable_reg & below_sync;

  // ----------------------------------------------------------------
  // Event detection
  // ----------------------------------------------------------------
  // Level sensitive: a held condition keeps setting the flag
  assign rise_hit = rise_en_reg & ~below_sync;
  assign drop_hit = drop_en_reg & below_sync;
  // Reserved code has no defined trip point, so it never detects
  assign level_valid = (level_reg != `SLM_LVL_RESERVED);
  // Gated by ready, which is low across every enable edge; sleep does not gate
  assign detect_event = ready & level_valid & (rise_hit | drop_hit);

  always @* begin
    flag_next = flag_reg;
    if (wr_status & ~hwdata[`SLM_STS_FLAG_BIT]) begin
      flag_next = 1'b0;
    end
    if (detect_event) begin
      flag_next = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Status register
  // ----------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_reg <= `SLM_RST_FLAG;
      ie_reg <= `SLM_RST_IE;
    end else begin
      flag_reg <= flag_next;
      if (wr_status) begin
        ie_reg <= hwdata[`SLM_STS_IE_BIT];
      end
    end
  end

  assign irq_req = flag_reg & ie_reg;
  assign wake_req = sleep_mode & irq_req;
  assign irq_vector_req = irq_req & global_irq_enable;

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always @* begin
    read_byte = 8'h00;
    case (dp_sel_reg)
      SEL_CTRL: begin
        read_byte[`SLM_CTL_ENABLE_BIT] = enable_reg;
        read_byte[`SLM_CTL_OUT_BIT] = out_bit;
        read_byte[`SLM_CTL_READY_BIT] = ready;
        read_byte[`SLM_CTL_RISE_BIT] = rise_en_reg;
        read_byte[`SLM_CTL_DROP_BIT] = drop_en_reg;
      end
      SEL_LEVEL: begin
        read_byte[`SLM_LVL_MSB:0] = level_reg;
      end
      SEL_STATUS: begin
        read_byte[`SLM_STS_FLAG_BIT] = flag_reg;
        read_byte[`SLM_STS_IE_BIT] = ie_reg;
      end
      default: begin
        read_byte = 8'h00;
      end
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= 32'h00000000;
    end else if (state_reg == ST_RDWAIT) begin
      hrdata_reg <= {24'h000000, read_byte};
    end
  end

  assign hrdata = hrdata_reg;

endmodule // slm_supply_level_monitor

// [verif/slm_supply_level_monitor_sva.sv]
// Port checker of the supply level monitor
`timescale 1ns/1ps
`include "slm_regs.vh"

module slm_supply_level_monitor_sva (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // Bus
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire hreadyout,
  input wire [31:0] hrdata,
  // Monitor side
  input wire analog_power_en,
  input wire [3:0] trip_level_sel,
  input wire sleep_mode,
  input wire global_irq_enable,
  input wire irq_req,
  input wire wake_req,
  input wire irq_vector_req
);
  // ----------------------------------------
  // Helper logic
  // ----------------------------------------
  localparam int SETTLE = `SLM_SETTLE_CYCLES;
  wire tk = hsel && htrans[1] && hready;
  reg wr_ctl_q, wr_lvl_q, wr_sts_q, rd_ctl_q;
  reg [11:0] en_cnt;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ctl_q <= 1'h0;
      wr_lvl_q <= 1'h0;
      wr_sts_q <= 1'h0;
      rd_ctl_q <= 1'h0;
      en_cnt <= 12'h000;
    end else begin
      if (hready) begin
        wr_ctl_q <= tk && hwrite && haddr == {`SLM_IDX_CONTROL, 2'h0};
        wr_lvl_q <= tk && hwrite && haddr == {`SLM_IDX_LEVEL, 2'h0};
        wr_sts_q <= tk && hwrite && haddr == {`SLM_IDX_STATUS, 2'h0};
        rd_ctl_q <= tk && !hwrite && haddr == {`SLM_IDX_CONTROL, 2'h0};
      end
      // Saturates so a long enabled run never wraps
      en_cnt <= !analog_power_en ? 12'h000 : (en_cnt == 12'hFFF ? en_cnt : en_cnt + 12'h001);
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_rd_taken; tk && !hwrite; endsequence
  sequence s_rd_answer; !hreadyout ##1 hreadyout; endsequence
  property p_rd_wait; s_rd_taken |=> s_rd_answer; endproperty
  property p_enable_wr; wr_ctl_q |=> analog_power_en == $past(hwdata[7]); endproperty
  property p_level_wr; wr_lvl_q |=> trip_level_sel == $past(hwdata[3:0]); endproperty
  property p_vector; irq_vector_req == (irq_req && global_irq_enable); endproperty
  property p_wake; wake_req == (sleep_mode && irq_req); endproperty
  property p_sticky; irq_req && !wr_sts_q |=> irq_req; endproperty
  property p_settle; $rose(irq_req) && !$past(wr_sts_q) |-> $past(en_cnt) >= SETTLE - 1; endproperty
  property p_rdy_low; rd_ctl_q && en_cnt < SETTLE - 1 |=> !hrdata[4]; endproperty
  property p_rdy_high; rd_ctl_q && en_cnt > SETTLE |=> hrdata[4]; endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
  a_enable_wr: assert property (p_enable_wr) else $error("enable not written");
  a_level_wr: assert property (p_level_wr) else $error("level not written");
  a_vector: assert property (p_vector) else $error("vector request wrong");
  a_wake: assert property (p_wake) else $error("wake request wrong");
  a_sticky: assert property (p_sticky) else $error("request dropped");
  a_settle: assert property (p_settle) else $error("event before settling");
  a_rdy_low: assert property (p_rdy_low) else $error("ready too early");
  a_rdy_high: assert property (p_rdy_high) else $error("ready too late");
endmodule // slm_supply_level_monitor_sva

bind slm_supply_level_monitor slm_supply_level_monitor_sva u_sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hrdata(hrdata), .analog_power_en(analog_power_en), .trip_level_sel(trip_level_sel), .sleep_mode(sleep_mode),
  .global_irq_enable(global_irq_enable), .irq_req(irq_req), .wake_req(wake_req), .irq_vector_req(irq_vector_req));

// [verif/slm_supply_level_monitor_tb.sv]
// Self-checking bench of the supply level monitor
`timescale 1ns/1ps
`include "slm_regs.vh"

module slm_supply_level_monitor_tb;
  localparam [29:0] CTL = `SLM_IDX_CONTROL;
  localparam [29:0] LVL = `SLM_IDX_LEVEL;
  localparam [29:0] STS = `SLM_IDX_STATUS;
  reg hclk = 1'h0, hresetn = 1'h0, por_bor_resetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
  reg supply_below_trip = 1'h0, sleep_mode = 1'h0, global_irq_enable = 1'h0;
  reg [1:0] htrans = 2'h0;
  reg [31:0] haddr = 32'h0, hwdata = 32'h0, rs = 32'h51FB8DF4, q;
  // Settled outputs: hresp, power, request, wake, vector, level
  reg [8:0] ob;
  wire hreadyout, hresp, analog_power_en, irq_req, wake_req, irq_vector_req;
  wire [31:0] hrdata;
  wire [3:0] trip_level_sel;
  int failures = 0, cmp_count = 0;
  always #5 hclk = ~hclk;
  slm_supply_level_monitor dut (.hclk(hclk), .hresetn(hresetn), .por_bor_resetn(por_bor_resetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .supply_below_trip(supply_below_trip),
    .analog_power_en(analog_power_en), .trip_level_sel(trip_level_sel), .sleep_mode(sleep_mode),
    .global_irq_enable(global_irq_enable), .irq_req(irq_req), .wake_req(wake_req), .irq_vector_req(irq_vector_req));
  // ----------------------------------------
  // Tasks and expectations
  // ----------------------------------------
  function automatic [31:0] xs(input [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic [31:0] exp_sts(input [1:0] dir, input below);
    return {30'h0, 1'h1, (dir[0] & below) | (dir[1] & ~below)};
  endfunction
  function automatic [31:0] exp_ctl(input [1:0] dir, input below, input rdy);
    return {24'h0, 1'h1, 1'h0, below, rdy, 2'h0, dir};
  endfunction
  function automatic [8:0] exp_out(input fl, input [1:0] sg, input [3:0] lvl);
    return {1'h0, 1'h1, fl, fl & sg[0], fl & sg[1], lvl};
  endfunction
  task automatic report_and_stop;
    $display("comparisons %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input [31:0] got, input [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Level seen at negedge is what the next rising edge samples
  task automatic wt;
    int n;
    n = 0;
    @(negedge hclk);
    while (hreadyout !== 1'h1) begin
      n++;
      if (n > 50) begin
        failures++;
        report_and_stop;
      end
      @(negedge hclk);
    end
    q = hrdata;
    ob = {hresp, analog_power_en, irq_req, wake_req, irq_vector_req, trip_level_sel};
    @(posedge hclk);
  endtask
  task automatic xfer(input w, input [29:0] idx, input [7:0] d);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {idx, 2'h0};
    wt;
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    wt;
  endtask
  task automatic rd(input [29:0] idx, input [31:0] exp);
    xfer(1'h0, idx, 8'h00);
    chk(q, exp);
  endtask
  task automatic do_rst(input p);
    hresetn <= 1'h0;
    por_bor_resetn <= p;
    repeat (5) @(posedge hclk);
    hresetn <= 1'h1;
    por_bor_resetn <= 1'h1;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    do_rst(1'h0);
    rd(CTL, 32'h0);
    rd(LVL, 32'h0);
    rd(30'h0, 32'h0);
    chk({23'h0, ob}, 32'h0);
    for (int i = 0; i < 8; i++) begin
      rs = xs(rs);
      xfer(1'h1, LVL, rs[7:0]);
      rd(LVL, {28'h0, rs[3:0]});
      chk({28'h0, ob[3:0]}, {28'h0, rs[3:0]});
    end
    xfer(1'h1, LVL, 8'h0F);
    rd(LVL, 32'hF);
    do_rst(1'h1);
    rd(LVL, 32'hF);
    do_rst(1'h0);
    rd(LVL, 32'h0);
    xfer(1'h1, LVL, 8'h07);
    // Every direction mode against both supply sides
    for (int m = 1; m < 4; m++) begin
      for (int b = 0; b < 2; b++) begin
        rs = xs(rs);
        sleep_mode <= rs[0];
        global_irq_enable <= rs[1];
        xfer(1'h1, CTL, 8'h00);
        supply_below_trip <= b[0];
        xfer(1'h1, CTL, {6'h20, m[1:0]});
        xfer(1'h1, STS, 8'h02);
        rd(CTL, exp_ctl(m[1:0], b[0], 1'h0));
        repeat (`SLM_SETTLE_CYCLES - 100) @(posedge hclk);
        rd(STS, 32'h2);
        repeat (200) @(posedge hclk);
        rd(CTL, exp_ctl(m[1:0], b[0], 1'h1));
        rd(STS, exp_sts(m[1:0], b[0]));
        chk({31'h0, ob[6]}, exp_sts(m[1:0], b[0]) & 32'h1);
        chk({23'h0, ob}, {23'h0, exp_out(exp_sts(m[1:0], b[0]) == 32'h3, rs[1:0], 4'h7)});
        xfer(1'h1, STS, 8'h02);
        rd(STS, exp_sts(m[1:0], b[0]));
      end
    end
    // Disable keeps the flag and drops ready at once
    xfer(1'h1, CTL, 8'h03);
    rd(CTL, 32'h03);
    rd(STS, 32'h3);
    xfer(1'h1, STS, 8'h02);
    rd(STS, 32'h2);
    // Reserved code never detects, even with the condition held
    xfer(1'h1, LVL, 8'h0F);
    xfer(1'h1, CTL, 8'h83);
    repeat (`SLM_SETTLE_CYCLES + 50) @(posedge hclk);
    rd(CTL, exp_ctl(2'h3, 1'h1, 1'h1));
    rd(STS, 32'h2);
    // Drop seen only once the supply really falls
    xfer(1'h1, CTL, 8'h00);
    supply_below_trip <= 1'h0;
    xfer(1'h1, LVL, 8'h05);
    xfer(1'h1, CTL, 8'h81);
    xfer(1'h1, STS, 8'h02);
    repeat (`SLM_SETTLE_CYCLES + 50) @(posedge hclk);
    rd(STS, 32'h2);
    supply_below_trip <= 1'h1;
    // Two synchroniser flops and the flag flop
    repeat (4) @(posedge hclk);
    rd(STS, 32'h3);
    chk({23'h0, ob}, {23'h0, exp_out(1'h1, rs[1:0], 4'h5)});
    rd(CTL, exp_ctl(2'h1, 1'h1, 1'h1));
    // Warm reset clears control and status but keeps the level
    do_rst(1'h1);
    rd(CTL, 32'h0);
    rd(STS, 32'h0);
    rd(LVL, 32'h5);
    report_and_stop;
  end
endmodule // slm_supply_level_monitor_tb
